// File: rtl/sdcb_cfg.svh
// Constants for the synthesizer divider configuration bank
`ifndef SDCB_CFG_SVH
`define SDCB_CFG_SVH
// Register select codes (low four bits of each word)
`define SDCB_REG_INT 4'h0
`define SDCB_REG_MAIN_FRACTION_NUMERATOR 4'h1
`define SDCB_REG_AUX 4'h2
`define SDCB_REG_PHASE 4'h3
`define SDCB_REG_REFCP 4'h4
`define SDCB_REG_DIVSEL 4'h6
// Register 0 fields
`define SDCB_CAL_BIT 21
`define SDCB_PRESC_BIT 20
`define SDCB_INT_HI 19
`define SDCB_INT_LO 4
// Register 1 field
`define SDCB_MAIN_FRACTION_NUMERATOR_HI 27
`define SDCB_MAIN_FRACTION_NUMERATOR_LO 4
// Register 2 fields
`define SDCB_AUX_FRACTION_NUMERATOR_HI 31
`define SDCB_AUX_FRACTION_NUMERATOR_LO 18
`define SDCB_AUX_FRACTION_MODULUS_HI 17
`define SDCB_AUX_FRACTION_MODULUS_LO 4
// Register 3 fields
`define SDCB_SDINH_BIT 30
`define SDCB_RESYNC_BIT 29
`define SDCB_PADJ_BIT 28
`define SDCB_PHASE_HI 27
`define SDCB_PHASE_LO 4
// Register 4 fields
`define SDCB_MUX_HI 29
`define SDCB_MUX_LO 27
`define SDCB_DBL_BIT 26
`define SDCB_HALF_BIT 25
`define SDCB_RCNT_HI 24
`define SDCB_RCNT_LO 15
`define SDCB_DBUF_BIT 14
`define SDCB_CP_HI 13
`define SDCB_CP_LO 10
`define SDCB_LVL_BIT 8
// Register 6 divider select field
`define SDCB_DIVSEL_HI 23
`define SDCB_DIVSEL_LO 21
// Reset values
`define SDCB_RST_WORD 32'h0000_0000
`define SDCB_RST_RCNT 10'h001
// Pulse length of calibration start and modulator reset, in cycles
`define SDCB_PULSE_CYC 1
`endif

// File: rtl/sdcb_pkg.sv
// Types shared by the synthesizer divider configuration bank
package sdcb_pkg;
  // Serial receiver state
  typedef enum logic [0:0] {
    SDCB_IDLE = 1'b0,
    SDCB_SHIFT = 1'b1
  } sdcb_rx_state_t;
endpackage

// File: rtl/sdcb_shift_rx.sv
// Serial word receiver: MSB-first shift register latched on load enable
`timescale 1ns/10ps
`include "sdcb_cfg.svh"
module sdcb_shift_rx #(
  parameter int WORD_W = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_en_in,
  input wire logic sdata_in,
  input wire logic load_en_in,
  output logic [WORD_W-1:0] word_out,
  output logic word_valid_out
);
  // ==========================================================
  // Elaboration check
  initial begin
    if (WORD_W < 8) begin
      $error("sdcb_shift_rx: word width too small");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    sdcb_pkg::sdcb_rx_state_t st; // Idle until first bit shifts in
    logic [WORD_W-1:0] shreg; // Shift register
    logic [WORD_W-1:0] word; // Latched word
    logic valid; // One-cycle latch pulse
    logic le_q; // Last load enable, for edge detect
  } sdcb_rx_t;

  sdcb_rx_t r;
  sdcb_rx_t next_r;

  // Shift and latch decision
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    next_r.le_q = load_en_in;
    // Bits enter LSB side so first bit ends up as MSB [RQ22]
    if (sclk_en_in && !load_en_in) begin
      next_r.shreg = {r.shreg[WORD_W-2:0], sdata_in};
      next_r.st = sdcb_pkg::SDCB_SHIFT;
    end
    // Rising load enable latches the whole word [RQ22]
    if (load_en_in && !r.le_q && r.st == sdcb_pkg::SDCB_SHIFT) begin
      next_r.word = r.shreg;
      next_r.valid = 1'b1;
      next_r.st = sdcb_pkg::SDCB_IDLE;
    end
  end

  // Register the state, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign word_out = r.word;
  assign word_valid_out = r.valid;
endmodule // sdcb_shift_rx

// File: rtl/sdcb_ref_div.sv
// Reference path: R counter with optional divide-by-two toggle
`timescale 1ns/10ps
`include "sdcb_cfg.svh"
module sdcb_ref_div #(
  parameter int RCNT_W = 10
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ref_edge_in,
  input wire logic [RCNT_W-1:0] ratio_in,
  input wire logic halve_in,
  output logic pfd_ref_out
);
  // ==========================================================
  // Elaboration check
  initial begin
    if (RCNT_W < 1 || RCNT_W > 16) begin
      $error("sdcb_ref_div: counter width out of range");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [RCNT_W-1:0] cnt; // Active reference edges counted
    logic pulse; // Counter terminal pulse
    logic tog; // Divide-by-two toggle
    logic out; // Registered output
  } sdcb_rd_t;

  sdcb_rd_t r;
  sdcb_rd_t next_r;

  // Count active edges; ratio 0 is treated as 1
  always_comb begin
    next_r = r;
    next_r.pulse = 1'b0;
    if (ref_edge_in) begin
      if (r.cnt + RCNT_W'(1) >= ratio_in) begin // [RQ17]
        next_r.cnt = '0;
        next_r.pulse = 1'b1;
        next_r.tog = ~r.tog; // Toggle gives a 50% duty output [RQ16]
      end else begin
        next_r.cnt = r.cnt + RCNT_W'(1);
      end
    end
    next_r.out = halve_in ? r.tog : r.pulse; // [RQ16]
  end

  // Register the state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pfd_ref_out = r.out;
endmodule // sdcb_ref_div

// File: rtl/sdcb_bank.sv
// Configuration register bank of the fractional-N synthesizer
`timescale 1ns/10ps
`include "sdcb_cfg.svh"

// ==========================================================
// Functional notes
// RQ1 - Low four bits select register 0..4; the code also decodes register 6 (divider select)
// RQ2 - Calibration bit set starts band selection
// RQ3 - Bit 20 picks prescaler 4/5 or 8/9
// RQ4 - Host keeps integer within prescaler range
// RQ5 - Host writes zeros above calibration bit
// RQ6 - Register 1 holds 24-bit main numerator
// RQ7 - Host keeps aux numerator below modulus
// RQ8 - Register 2 holds 14-bit aux modulus
// RQ9 - Register 0 write resets modulator unless inhibited
// RQ10 - Resync works only with aux numerator zero
// RQ11 - Phase adjust advances phase each update
// RQ12 - Host never enables resync with adjust
// RQ13 - Phase value is fraction of turn
// RQ14 - Host avoids divider outputs on test mux
// RQ15 - Doubler bit chooses one or both edges
// RQ16 - Halver bit inserts divide-by-two toggle
// RQ17 - Reference counter divides by 1 to 1023
// RQ18 - Buffer bit shadows divider select field
// RQ19 - Pump current from four-bit code
// RQ20 - Level bit picks 1.8 or 3.3 V
// RQ21 - Shadowed fields apply on register 0 write
// RQ22 - MSB first shift, latched on load enable
module sdcb_bank #(
  parameter int WORD_W = 32,
  parameter int PHASE_W = 24,
  parameter int RCNT_W = 10
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_en_in, // One-cycle strobe per serial bit
  input wire logic sdata_in,
  input wire logic load_en_in,
  input wire logic ref_in, // Reference input, sampled
  output logic [15:0] int_value_out,
  output logic prescaler_sel_out,
  output logic [23:0] main_fraction_numerator_out,
  output logic [13:0] aux_fraction_numerator_out,
  output logic [13:0] aux_fraction_modulus_out,
  output logic vco_cal_start_out,
  output logic mod_reset_out,
  output logic resync_active_out,
  output logic [PHASE_W-1:0] phase_accum_out,
  output logic [2:0] test_output_selector_out,
  output logic reference_doubler_enable_out,
  output logic reference_halver_enable_out,
  output logic [RCNT_W-1:0] ref_ratio_out,
  output logic [3:0] pump_current_code_out,
  output logic test_output_level_select_out,
  output logic [2:0] divider_select_out,
  output logic pfd_ref_out
);
  // ==========================================================
  // Elaboration check
  initial begin
    if (WORD_W != 32 || PHASE_W != 24 || RCNT_W != 10) begin
      $error("sdcb_bank: widths fixed by the word layout");
    end
  end

  // ==========================================================
  // Received word
  logic [WORD_W-1:0] rx_word; // Latched serial word
  logic rx_valid; // One-cycle pulse per word
  logic ref_edge; // Active reference edge strobe
  logic pfd_ref; // Output of reference divider

  sdcb_shift_rx #(.WORD_W(WORD_W)) u_rx (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sclk_en_in(sclk_en_in),
    .sdata_in(sdata_in),
    .load_en_in(load_en_in),
    .word_out(rx_word),
    .word_valid_out(rx_valid)
  );

  // ==========================================================
  // State
  typedef struct packed {
    logic [WORD_W-1:0] r0; // Integer, prescaler, calibration
    logic [WORD_W-1:0] r1_sh; // Main numerator shadow
    logic [WORD_W-1:0] r2_sh; // Aux numerator and modulus shadow
    logic [WORD_W-1:0] r3_sh; // Phase control shadow
    logic [WORD_W-1:0] r4_sh; // Reference and pump shadow
    logic [WORD_W-1:0] r1; // Active copies below
    logic [WORD_W-1:0] r2;
    logic [WORD_W-1:0] r3;
    logic [WORD_W-1:0] r4;
    logic [2:0] div_sh; // Divider select as written
    logic [2:0] div_act; // Divider select in force
    logic [PHASE_W-1:0] phase; // Accumulated output phase
    logic cal; // Calibration start pulse
    logic mrst; // Modulator reset pulse
    logic ref_q; // Previous reference sample
    logic edge_s; // Active edge strobe
    logic phase_detector; // Registered divider output
    logic rsy; // Resync allowed, registered so the output is a flop
  } sdcb_st_t;

  sdcb_st_t r;
  sdcb_st_t next_r;

  // ==========================================================
  // Register writes and register 0 side effects
  always_comb begin
    next_r = r;
    next_r.cal = 1'b0;
    next_r.mrst = 1'b0;
    next_r.ref_q = ref_in;
    next_r.phase_detector = pfd_ref;
    // Falling edge only, or both edges when doubled [RQ15]
    if (r.r4[`SDCB_DBL_BIT]) begin
      next_r.edge_s = ref_in ^ r.ref_q;
    end else begin
      next_r.edge_s = r.ref_q & ~ref_in;
    end
    if (rx_valid) begin
      unique case (rx_word[3:0]) // [RQ1]
        `SDCB_REG_INT: begin
          next_r.r0 = rx_word;
          // Shadowed fields move to the active set now [RQ21]
          next_r.r1 = r.r1_sh;
          next_r.r2 = r.r2_sh;
          next_r.r3 = r.r3_sh;
          next_r.r4 = r.r4_sh;
          if (r.r4_sh[`SDCB_DBUF_BIT]) begin
            next_r.div_act = r.div_sh; // [RQ18]
          end
          next_r.cal = rx_word[`SDCB_CAL_BIT]; // [RQ2]
          // Shadowed inhibit bit, applied with this write, decides modulator reset [RQ9]
          next_r.mrst = ~r.r3_sh[`SDCB_SDINH_BIT];
          // Phase advances by programmed step on each update [RQ11] [RQ13]
          if (r.r3_sh[`SDCB_PADJ_BIT]) begin
            next_r.phase = r.phase + r.r3_sh[`SDCB_PHASE_HI:`SDCB_PHASE_LO];
          end
        end
        `SDCB_REG_MAIN_FRACTION_NUMERATOR: next_r.r1_sh = rx_word; // [RQ6]
        `SDCB_REG_AUX: next_r.r2_sh = rx_word; // [RQ8]
        `SDCB_REG_PHASE: next_r.r3_sh = rx_word;
        `SDCB_REG_REFCP: next_r.r4_sh = rx_word;
        `SDCB_REG_DIVSEL: begin
          next_r.div_sh = rx_word[`SDCB_DIVSEL_HI:`SDCB_DIVSEL_LO];
          // Unbuffered select takes effect at once [RQ18]
          if (!r.r4[`SDCB_DBUF_BIT]) begin
            next_r.div_act = rx_word[`SDCB_DIVSEL_HI:`SDCB_DIVSEL_LO];
          end
        end
        default: ; // Other registers are outside this bank
      endcase
    end
    // Computed from the next active set so it moves with the fields [RQ10]
    next_r.rsy = next_r.r3[`SDCB_RESYNC_BIT] &
      (next_r.r2[`SDCB_AUX_FRACTION_NUMERATOR_HI:`SDCB_AUX_FRACTION_NUMERATOR_LO] == 14'h0000);
  end

  // Register the state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.r4[`SDCB_RCNT_HI:`SDCB_RCNT_LO] <= `SDCB_RST_RCNT;
      r.r4_sh[`SDCB_RCNT_HI:`SDCB_RCNT_LO] <= `SDCB_RST_RCNT;
    end else begin
      r <= next_r;
    end
  end

  assign ref_edge = r.edge_s;

  // ==========================================================
  // Reference path
  sdcb_ref_div #(.RCNT_W(RCNT_W)) u_ref (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ref_edge_in(ref_edge),
    .ratio_in(r.r4[`SDCB_RCNT_HI:`SDCB_RCNT_LO]), // [RQ17]
    .halve_in(r.r4[`SDCB_HALF_BIT]), // [RQ16]
    .pfd_ref_out(pfd_ref)
  );

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign int_value_out = r.r0[`SDCB_INT_HI:`SDCB_INT_LO];
  assign prescaler_sel_out = r.r0[`SDCB_PRESC_BIT]; // [RQ3]
  assign main_fraction_numerator_out = r.r1[`SDCB_MAIN_FRACTION_NUMERATOR_HI:`SDCB_MAIN_FRACTION_NUMERATOR_LO]; // [RQ6]
  assign aux_fraction_numerator_out = r.r2[`SDCB_AUX_FRACTION_NUMERATOR_HI:`SDCB_AUX_FRACTION_NUMERATOR_LO];
  assign aux_fraction_modulus_out = r.r2[`SDCB_AUX_FRACTION_MODULUS_HI:`SDCB_AUX_FRACTION_MODULUS_LO]; // [RQ8]
  assign vco_cal_start_out = r.cal; // [RQ2]
  assign mod_reset_out = r.mrst; // [RQ9]
  // Resync only counts while aux numerator is zero [RQ10]
  assign resync_active_out = r.rsy;
  assign phase_accum_out = r.phase; // [RQ13]
  assign test_output_selector_out = r.r4[`SDCB_MUX_HI:`SDCB_MUX_LO];
  assign reference_doubler_enable_out = r.r4[`SDCB_DBL_BIT]; // [RQ15]
  assign reference_halver_enable_out = r.r4[`SDCB_HALF_BIT];
  assign ref_ratio_out = r.r4[`SDCB_RCNT_HI:`SDCB_RCNT_LO];
  assign pump_current_code_out = r.r4[`SDCB_CP_HI:`SDCB_CP_LO]; // [RQ19]
  assign test_output_level_select_out = r.r4[`SDCB_LVL_BIT]; // [RQ20]
  assign divider_select_out = r.div_act;
  assign pfd_ref_out = r.phase_detector;
endmodule // sdcb_bank

// File: dv/sdcb_host_model.sv
// Host model driving the serial configuration link
`timescale 1ns/10ps
module sdcb_host_model (
  input wire logic clk_in,
  output logic sclk_en_out,
  output logic sdata_out,
  output logic load_en_out
);
  // Idle link: strobes low
  initial begin
    sclk_en_out = 1'b0;
    sdata_out = 1'b0;
    load_en_out = 1'b0;
  end
  // ==========================================
  // Word transfer
  // Select code rides in the low nibble
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_in);
      sclk_en_out <= 1'b1;
      sdata_out <= w[i]; // MSB first
    end
    @(posedge clk_in);
    sclk_en_out <= 1'b0;
    sdata_out <= ~w[0]; // Released line shows no stale bit
    load_en_out <= 1'b1; // Latch pulse
    @(posedge clk_in);
    load_en_out <= 1'b0;
    // Let the two-edge answer land
    repeat (3) @(posedge clk_in);
  endtask
endmodule // sdcb_host_model

// File: dv/sdcb_bank_asserts.sv
// Port checker for the configuration bank
`timescale 1ns/10ps
module sdcb_bank_asserts #(
  parameter int PHASE_W = 24
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_en_in,
  input wire logic sdata_in,
  input wire logic load_en_in,
  input wire logic [15:0] int_value_out,
  input wire logic prescaler_sel_out,
  input wire logic [23:0] main_fraction_numerator_out,
  input wire logic [13:0] aux_fraction_numerator_out,
  input wire logic vco_cal_start_out,
  input wire logic mod_reset_out,
  input wire logic resync_active_out,
  input wire logic [3:0] pump_current_code_out
);
  // ==========================================
  // Shadow of the serial word, as the host sent it
  logic [31:0] sh;
  logic [31:0] wl;
  logic ld_q;
  wire ld = load_en_in && !ld_q;
  wire r0 = ld && (sh[3:0] == 4'h0);
  wire cal_w = r0 && sh[21];
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sh <= 32'h0;
      wl <= 32'h0;
      ld_q <= 1'b0;
    end else begin
      ld_q <= load_en_in;
      if (sclk_en_in && !load_en_in) begin
        sh <= {sh[30:0], sdata_in};
      end
      if (ld) begin
        wl <= sh;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================
  // Properties
  a_cal_pulse: assert property (cal_w |-> ##2 vco_cal_start_out ##1 !vco_cal_start_out)
    else $error("calibration pulse missing");
  a_cal_cause: assert property (vco_cal_start_out |-> $past(cal_w, 2))
    else $error("calibration without cause");
  a_mrst_cause: assert property (mod_reset_out |-> $past(r0, 2))
    else $error("modulator reset without write");
  a_int_load: assert property (r0 |-> ##2 int_value_out == wl[19:4] && prescaler_sel_out == wl[20])
    else $error("integer or prescaler wrong");
  a_code_ignored: assert property (ld && sh[3:0] > 4'h6 |->
    ##1 ($stable(int_value_out) && $stable(pump_current_code_out))[*2])
    else $error("unused code changed state");
  a_resync_gate: assert property (resync_active_out |-> aux_fraction_numerator_out == 14'h0)
    else $error("resync with nonzero aux numerator");
  a_int_hold: assert property ($changed(int_value_out) |-> $past(r0, 2))
    else $error("integer changed without write");
  a_shadow_hold: assert property ($changed(pump_current_code_out)
    || $changed(main_fraction_numerator_out) |-> $past(r0, 2))
    else $error("shadowed field applied early");
endmodule // sdcb_bank_asserts
bind sdcb_bank sdcb_bank_asserts #(.PHASE_W(PHASE_W)) sdcb_bank_asserts_inst (.*);

// File: dv/sdcb_bank_test.sv
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module sdcb_bank_test;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ref_in = 1'b0;
  logic sclk_en, sdata, load_en, presc, cal, mrst, rsy, dbl, hlf, lvl, phase_detector;
  logic [15:0] int_v;
  logic [23:0] main_fraction_numerator, phase;
  logic [13:0] fr2, md2;
  logic [2:0] mux, dsel;
  logic [9:0] ratio;
  logic [3:0] cp;
  int n_fail = 0;
  int check_count = 0;
  int n_cal = 0;
  int n_mr = 0;
  // 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // Reference toggles; pulse counters
  always @(posedge clk_in) begin
    ref_in <= ~ref_in;
  end
  // Pulses are counted mid-cycle, where they are settled
  always @(negedge clk_in) begin
    n_cal = n_cal + int'(cal === 1'b1);
    n_mr = n_mr + int'(mrst === 1'b1);
  end
  sdcb_host_model sdcb_host_model_inst (.clk_in(clk_in), .sclk_en_out(sclk_en),
    .sdata_out(sdata), .load_en_out(load_en));
  sdcb_bank sdcb_bank_inst (.clk_in(clk_in), .nrst_in(nrst_in), .sclk_en_in(sclk_en),
    .sdata_in(sdata), .load_en_in(load_en), .ref_in(ref_in), .int_value_out(int_v),
    .prescaler_sel_out(presc), .main_fraction_numerator_out(main_fraction_numerator),
    .aux_fraction_numerator_out(fr2), .aux_fraction_modulus_out(md2),
    .vco_cal_start_out(cal), .mod_reset_out(mrst), .resync_active_out(rsy),
    .phase_accum_out(phase), .test_output_selector_out(mux),
    .reference_doubler_enable_out(dbl), .reference_halver_enable_out(hlf),
    .ref_ratio_out(ratio), .pump_current_code_out(cp),
    .test_output_level_select_out(lvl), .divider_select_out(dsel), .pfd_ref_out(phase_detector));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    sdcb_host_model_inst.send_word(w);
  endtask
  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #50000;
    n_fail++;
    results();
  end
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    chk(ratio, 32'h1);
    chk({int_v, cp, dsel}, 32'h0);
    wr(32'h0F00_1231);
    wr({14'd5, 14'd9, 4'h2});
    wr({4'h1, 24'h40_0000, 4'h3});
    wr(32'h0FFF_A904);
    chk(cp, 32'h0);
    wr({10'h0, 1'b1, 1'b1, 16'd75, 4'h0});
    chk({presc, int_v}, 32'h1_004B);
    chk(main_fraction_numerator, 32'hF0_0123);
    chk({fr2, md2}, {4'h0, 14'd5, 14'd9});
    chk(phase, 32'h40_0000);
    chk({mux, dbl, hlf, ratio, cp, lvl}, 32'h3FFF5);
    chk(n_cal, 32'h1);
    chk(n_mr, 32'h1);
    wr({4'h5, 24'hC0_0000, 4'h3});
    wr({10'h0, 1'b0, 1'b0, 16'd23, 4'h0});
    chk(phase, 32'h0);
    chk({n_cal[3:0], n_mr[3:0], 7'h0, presc, int_v}, 32'h1100_0017);
    wr(32'hFFFF_FFF5);
    wr(32'hFFFF_FFFF);
    wr({10'h0, 1'b0, 1'b0, 16'd23, 4'h0});
    chk({cp, main_fraction_numerator}, 32'hAF0_0123);
    chk(phase, 32'hC0_0000);
    wr({8'h0, 3'h5, 21'h6});
    chk(dsel, 32'h5);
    wr(32'h0FFF_E904);
    wr({10'h0, 1'b0, 1'b0, 16'd23, 4'h0});
    wr({8'h0, 3'h2, 21'h6});
    chk(dsel, 32'h5);
    wr({14'd0, 14'd9, 4'h2});
    wr({4'h2, 24'h0, 4'h3});
    wr({10'h0, 1'b1, 1'b0, 16'd23, 4'h0});
    chk({dsel, rsy}, 32'h5);
    wr(32'h0400_8004);
    wr({10'h0, 1'b0, 1'b0, 16'd23, 4'h0});
    repeat (4) @(posedge clk_in);
    chk(phase_detector, 32'h1);
    results();
  end
endmodule // sdcb_bank_test
